// [src/vproc_pkg.sv]
// Constants and types shared by the video processor control receiver
`default_nettype none
package vproc_pkg;

  // Two-wire bus addressing
  localparam logic [6:0] SLAVE_ADDR      = 7'h44;
  localparam logic [7:0] SUB_FIRST       = 8'h00;
  localparam logic [7:0] SUB_LAST_DIRECT = 8'h0E;
  localparam logic [7:0] SUB_WRAP        = 8'h0F;
  localparam logic [7:0] SUB_HUE         = 8'h03;
  localparam logic [7:0] SUB_CTRL1       = 8'h0C;
  localparam logic [7:0] SUB_CTRL2       = 8'h0D;
  localparam logic [7:0] SUB_CTRL3       = 8'h0E;
  localparam int         NUM_ALIGN       = 12;
  localparam int         ALIGN_W         = 6;
  localparam logic [3:0] BIT_COUNT_FULL  = 4'h8;

  // Values after reset
  localparam logic [5:0] ALIGN_RESET = 6'h01;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Control register 1 fields
  localparam int C1_TWO_LEVEL_SC = 7;
  localparam int C1_DELAY_OFF    = 6;
  localparam int C1_BUFFERED     = 5;
  localparam int C1_NTSC         = 3;
  // Control register 2 fields
  localparam int C2_DOUBLE_LINES = 6;
  localparam int C2_FULL_BLACK   = 5;
  localparam int C2_BLACK_CTL    = 4;
  localparam int C2_DIS2         = 3;
  localparam int C2_FORCE2       = 2;
  localparam int C2_DIS1         = 1;
  localparam int C2_FORCE1       = 0;
  // Control register 3 fields
  localparam int C3_ADAPT_BLACK  = 7;
  localparam int C3_LUMA_HIGH    = 6;
  localparam int C3_LUMA_OUT     = 5;
  localparam int C3_MODE2        = 3;
  localparam int C3_BLUE_STRETCH = 2;
  localparam int C3_REL_CUTOFF   = 1;
  localparam int C3_PEAK_TC      = 0;

  // Peak dark window, in lines after vertical blanking
  localparam logic [9:0] PD_START_LINE = 10'h010;
  localparam logic [9:0] PD_END_NTSC   = 10'h0E0;
  localparam logic [9:0] PD_END_PAL    = 10'h110;
  localparam logic [9:0] LINE_CNT_MAX  = 10'h3FF;
  localparam logic [1:0] VBLANK_LINES  = 2'h2;

  // Register bus map
  localparam logic [7:0] APB_STATUS_ADDR = 8'h40;

  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_SUB  = 2'b01,
    KIND_DATA = 2'b10
  } kind_e;

  typedef enum logic [1:0] {
    SRC_LUMA_CD = 2'b00,
    SRC_RGB1    = 2'b01,
    SRC_RGB2    = 2'b10
  } source_e;

  typedef struct packed {
    logic blank;
    logic line;
    logic burst;
  } sc_pulses_s;

  typedef struct packed {
    logic two_level_sandcastle_select;
    logic delay_off;
    logic buffered_write_enable;
    logic ntsc_matrix_select;
    logic double_line_count;
    logic full_screen_black;
    logic black_control_off;
    logic switch_two_pin_disable;
    logic force_source_two_on;
    logic switch_one_pin_disable;
    logic force_source_one_on;
    logic adaptive_black_enable;
    logic luma_high_level;
    logic mode_two;
    logic blue_stretch;
    logic relative_cutoff;
    logic peak_time_constant;
    logic luma_not_hue_output_select;
  } ctrl_s;

endpackage
`default_nettype wire

// [src/twi_byte_rx.sv]
// Two-wire slave receiver: framing, byte shifting and acknowledge drive
`default_nettype none
module twi_byte_rx (
  input  wire logic            mclk,
  input  wire logic            resetn,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  input  wire logic            busy,
  input  wire logic            ack_ok,
  output logic                 sda_out,
  output logic                 sda_oe,
  output logic [7:0]           rx_byte,
  output vproc_pkg::kind_e     rx_kind,
  output logic                 byte_stb
);
  import vproc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BITS = 2'b01,
    ST_ACK  = 2'b10,
    ST_SKIP = 2'b11
  } rx_state_e;

  rx_state_e   state_r;
  logic [3:0]  bit_cnt_r;
  logic [2:0]  scl_sync_r;
  logic [2:0]  sda_sync_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        decide;
  logic        accept;

  // Bit 0 feeds only bit 1; bits 1 and 2 give level and previous level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  assign scl_rise   = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall   = ~scl_sync_r[1] & scl_sync_r[2];
  assign start_cond = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] & ~sda_sync_r[1];
  assign stop_cond  = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] & sda_sync_r[1];
  assign decide     = (state_r == ST_BITS) && scl_fall && (bit_cnt_r == BIT_COUNT_FULL);

  always_comb begin
    if (rx_kind == KIND_ADDR) begin
      accept = (rx_byte[7:1] == SLAVE_ADDR) && !rx_byte[0] && !busy;
    end else begin
      accept = ack_ok;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      rx_kind   <= KIND_ADDR;
    end else if (start_cond) begin
      state_r   <= ST_BITS;
      bit_cnt_r <= 4'h0;
      rx_kind   <= KIND_ADDR;
    end else if (stop_cond) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_BITS: begin
          if (scl_rise && bit_cnt_r != BIT_COUNT_FULL) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (decide) begin
            state_r <= accept ? ST_ACK : ST_SKIP;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_r   <= ST_BITS;
            bit_cnt_r <= 4'h0;
            rx_kind   <= (rx_kind == KIND_ADDR) ? KIND_SUB : KIND_DATA;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_byte <= 8'h00;
    end else if (state_r == ST_BITS && scl_rise && bit_cnt_r != BIT_COUNT_FULL) begin
      rx_byte <= {rx_byte[6:0], sda_sync_r[1]};
    end
  end

  // Only accepted subaddress and data bytes reach the register logic
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      byte_stb <= 1'b0;
    end else begin
      byte_stb <= decide && accept && (rx_kind != KIND_ADDR);
    end
  end

  // Pulled low for the whole acknowledge clock, released on its falling edge
  assign sda_out = 1'b0;
  assign sda_oe  = (state_r == ST_ACK);

endmodule
`default_nettype wire

// [src/video_proc_i2c_ctrl_receiver.sv]
// Control receiver of the video processor: registers, sandcastle, peak dark window
`default_nettype none
// What this block does
// - Answers only write transfers to slave address 1000100; receive only.
// - Unbuffered: one subaddress, then any number of data bytes, auto-incremented.
// - Subaddress wraps 0F to 00; 0F acknowledged only when reached that way.
// - Direct subaddress above 0E not acknowledged and changes nothing.
// - All eight subaddress bits compared.
// - Buffered mode: no increment, one subaddress and one data byte per transfer.
// - Three sandcastle thresholds, or two when two-level select set.
// - Peak dark detector off in blanking; line count starts at vertical blank end.
// - Window opens line 16, closes line 224 for NTSC, 272 for PAL.
// - Double line count doubles every window line number.
// - Black level shift from peak dark result only when adaptive black enabled.
// - Output select switches pin between luma and six-bit hue voltage.
// - Luma output without sync; luma black level follows hue register while luma output selected, else 00.
// - Every six-bit alignment register resets to 01.
// - Buffered byte copied in next vertical blank; no acknowledge until copied.
module video_proc_i2c_ctrl_receiver (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic [2:0]            sc_compare,
  input  wire logic                  source_one_switch_pin,
  input  wire logic                  source_two_switch_pin,
  input  wire logic [5:0]            peak_dark_result,
  output vproc_pkg::sc_pulses_s      sc_pulses,
  output logic                       peak_dark_enable,
  output logic [5:0]                 black_shift,
  output logic                       luma_output_active,
  output logic [5:0]                 hue_dac,
  output logic [5:0]                 luma_black_level,
  output vproc_pkg::source_e         source_select,
  output vproc_pkg::ctrl_s           ctrl_bits,
  output logic [11:0][5:0]           align_codes,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr
);
  import vproc_pkg::*;

  logic [7:0]        rx_byte;
  kind_e             rx_kind;
  logic              byte_stb;
  logic              ack_ok;
  logic [7:0]        subaddr_r;
  logic              buf_mode_r;
  logic              data_seen_r;
  logic              pending_r;
  logic [7:0]        buf_addr_r;
  logic [7:0]        buf_data_r;
  logic [7:0]        ctrl1_r;
  logic [7:0]        ctrl2_r;
  logic [7:0]        ctrl3_r;
  logic              wr_en;
  logic [7:0]        wr_addr;
  logic [7:0]        wr_data;
  logic              copy_now;
  logic              direct_wr;
  logic [10:0]       pin_sync1_r;
  logic [10:0]       pin_sync2_r;
  logic              line_prev_r;
  logic              blank_prev_r;
  logic [1:0]        vcount_r;
  logic              vblank_r;
  logic              counting_r;
  logic [9:0]        line_cnt_r;
  logic [9:0]        win_start;
  logic [9:0]        win_end;
  logic              in_window;
  logic              sel_two;
  logic              sel_one;
  logic [31:0]       rd_word;
  logic              rd_ok;
  logic              rd_ok_r;
  logic [5:0]        apb_idx;
  logic [7:0]        unused_wdata;

  twi_byte_rx u_rx (
    .mclk     (mclk),
    .resetn   (resetn),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .busy     (pending_r),
    .ack_ok   (ack_ok),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .rx_byte  (rx_byte),
    .rx_kind  (rx_kind),
    .byte_stb (byte_stb)
  );

  // Acknowledge decision for the byte just shifted in
  always_comb begin
    ack_ok = 1'b0;
    if (rx_kind == KIND_SUB) begin
      // Direct range check; also full byte compare
      ack_ok = (rx_byte <= SUB_LAST_DIRECT) && !pending_r;
    end else if (rx_kind == KIND_DATA) begin
      ack_ok = buf_mode_r ? !data_seen_r : 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      subaddr_r   <= SUB_FIRST;
      buf_mode_r  <= 1'b0;
      data_seen_r <= 1'b0;
    end else if (byte_stb && rx_kind == KIND_SUB) begin
      subaddr_r   <= rx_byte;
      buf_mode_r  <= ctrl1_r[C1_BUFFERED];
      data_seen_r <= 1'b0;
    end else if (byte_stb && rx_kind == KIND_DATA) begin
      data_seen_r <= 1'b1;
      if (!buf_mode_r) begin
        subaddr_r <= (subaddr_r == SUB_WRAP) ? SUB_FIRST : subaddr_r + 8'h01;
      end
    end
  end

  // Latch and hold off; a new byte wins over the copy's clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pending_r  <= 1'b0;
      buf_addr_r <= SUB_FIRST;
      buf_data_r <= 8'h00;
    end else if (byte_stb && rx_kind == KIND_DATA && buf_mode_r) begin
      pending_r  <= 1'b1;
      buf_addr_r <= subaddr_r;
      buf_data_r <= rx_byte;
    end else if (copy_now) begin
      pending_r <= 1'b0;
    end
  end

  assign copy_now  = pending_r && vblank_r;
  assign direct_wr = byte_stb && (rx_kind == KIND_DATA) && !buf_mode_r;
  assign wr_en     = direct_wr || copy_now;
  assign wr_addr   = copy_now ? buf_addr_r : subaddr_r;
  assign wr_data   = copy_now ? buf_data_r : rx_byte;

  // Reset to 01; low six bits kept
  for (genvar g = 0; g < NUM_ALIGN; g++) begin : g_align
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        align_codes[g] <= ALIGN_RESET;
      end else if (wr_en && wr_addr == 8'(g)) begin
        align_codes[g] <= wr_data[ALIGN_W-1:0];
      end
    end
  end

  // Subaddress 0F has no storage behind it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_r <= CTRL_RESET;
      ctrl2_r <= CTRL_RESET;
      ctrl3_r <= CTRL_RESET;
    end else if (wr_en) begin
      if (wr_addr == SUB_CTRL1) begin
        ctrl1_r <= wr_data;
      end else if (wr_addr == SUB_CTRL2) begin
        ctrl2_r <= wr_data;
      end else if (wr_addr == SUB_CTRL3) begin
        ctrl3_r <= wr_data;
      end
    end
  end

  assign ctrl_bits = '{
    two_level_sandcastle_select: ctrl1_r[C1_TWO_LEVEL_SC],
    delay_off:                   ctrl1_r[C1_DELAY_OFF],
    buffered_write_enable:       ctrl1_r[C1_BUFFERED],
    ntsc_matrix_select:          ctrl1_r[C1_NTSC],
    double_line_count:           ctrl2_r[C2_DOUBLE_LINES],
    full_screen_black:           ctrl2_r[C2_FULL_BLACK],
    black_control_off:           ctrl2_r[C2_BLACK_CTL],
    switch_two_pin_disable:      ctrl2_r[C2_DIS2],
    force_source_two_on:         ctrl2_r[C2_FORCE2],
    switch_one_pin_disable:      ctrl2_r[C2_DIS1],
    force_source_one_on:         ctrl2_r[C2_FORCE1],
    adaptive_black_enable:       ctrl3_r[C3_ADAPT_BLACK],
    luma_high_level:             ctrl3_r[C3_LUMA_HIGH],
    mode_two:                    ctrl3_r[C3_MODE2],
    blue_stretch:                ctrl3_r[C3_BLUE_STRETCH],
    relative_cutoff:             ctrl3_r[C3_REL_CUTOFF],
    peak_time_constant:          ctrl3_r[C3_PEAK_TC],
    luma_not_hue_output_select:  ctrl3_r[C3_LUMA_OUT]
  };

  // Asynchronous pins; the result bus may skew one cycle across bits
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_sync1_r <= 11'h000;
      pin_sync2_r <= 11'h000;
    end else begin
      pin_sync1_r <= {peak_dark_result, source_two_switch_pin, source_one_switch_pin, sc_compare};
      pin_sync2_r <= pin_sync1_r;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sc_pulses <= '0;
    end else begin
      sc_pulses.blank <= pin_sync2_r[0];
      sc_pulses.line  <= pin_sync2_r[1];
      sc_pulses.burst <= ctrl1_r[C1_TWO_LEVEL_SC] ? pin_sync2_r[1] : pin_sync2_r[2];
    end
  end

  // Vertical blank: a blank pulse spanning two or more line pulses
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      line_prev_r  <= 1'b0;
      blank_prev_r <= 1'b0;
      vcount_r     <= 2'h0;
      vblank_r     <= 1'b0;
    end else begin
      line_prev_r  <= sc_pulses.line;
      blank_prev_r <= sc_pulses.blank;
      if (!sc_pulses.blank) begin
        vcount_r <= 2'h0;
        vblank_r <= 1'b0;
      end else if (sc_pulses.line && !line_prev_r && vcount_r != VBLANK_LINES) begin
        vcount_r <= vcount_r + 2'h1;
        vblank_r <= (vcount_r + 2'h1) == VBLANK_LINES;
      end
    end
  end

  // Line counter restarts at the end of vertical blank
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      counting_r <= 1'b0;
      line_cnt_r <= 10'h000;
    end else if (vblank_r && !sc_pulses.blank && blank_prev_r) begin
      counting_r <= 1'b1;
      line_cnt_r <= 10'h000;
    end else if (counting_r && sc_pulses.line && !line_prev_r && line_cnt_r != LINE_CNT_MAX) begin
      line_cnt_r <= line_cnt_r + 10'h001;
    end
  end

  // Window limits; doubled for progressive scan
  always_comb begin
    win_start = PD_START_LINE;
    win_end   = ctrl1_r[C1_NTSC] ? PD_END_NTSC : PD_END_PAL;
    if (ctrl2_r[C2_DOUBLE_LINES]) begin
      win_start = {win_start[8:0], 1'b0};
      win_end   = {win_end[8:0], 1'b0};
    end
  end

  assign in_window = counting_r && (line_cnt_r >= win_start) && (line_cnt_r < win_end);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peak_dark_enable <= 1'b0;
    end else begin
      peak_dark_enable <= in_window && !sc_pulses.blank;
    end
  end

  // Shift gated; pin select; black level from hue
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      black_shift        <= 6'h00;
      luma_output_active <= 1'b0;
      hue_dac            <= ALIGN_RESET;
      luma_black_level   <= 6'h00;
    end else begin
      black_shift        <= ctrl3_r[C3_ADAPT_BLACK] ? pin_sync2_r[10:5] : 6'h00;
      luma_output_active <= ctrl3_r[C3_LUMA_OUT];
      hue_dac            <= align_codes[SUB_HUE[3:0]];
      luma_black_level   <= ctrl3_r[C3_LUMA_OUT] ? align_codes[SUB_HUE[3:0]] : 6'h00;
    end
  end

  // Source priority with disable and force
  assign sel_two = ctrl2_r[C2_FORCE2] || (pin_sync2_r[4] && !ctrl2_r[C2_DIS2]);
  assign sel_one = ctrl2_r[C2_FORCE1] || (pin_sync2_r[3] && !ctrl2_r[C2_DIS1]);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      source_select <= SRC_LUMA_CD;
    end else if (sel_two) begin
      source_select <= SRC_RGB2;
    end else if (sel_one) begin
      source_select <= SRC_RGB1;
    end else begin
      source_select <= SRC_LUMA_CD;
    end
  end

  // Read-only register view; data captured in setup so the access needs no wait
  assign apb_idx      = paddr[7:2];
  assign unused_wdata = pwdata[7:0];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (paddr[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (paddr == APB_STATUS_ADDR) begin
      rd_word = {18'h00000, pending_r, vblank_r, peak_dark_enable, counting_r, line_cnt_r};
    end else if (apb_idx < 6'(NUM_ALIGN)) begin
      rd_word = {26'h0000000, align_codes[apb_idx[3:0]]};
    end else if (apb_idx == SUB_CTRL1[5:0]) begin
      rd_word = {24'h000000, ctrl1_r};
    end else if (apb_idx == SUB_CTRL2[5:0]) begin
      rd_word = {24'h000000, ctrl2_r};
    end else if (apb_idx == SUB_CTRL3[5:0]) begin
      rd_word = {24'h000000, ctrl3_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      rd_ok_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_word;
      rd_ok_r <= rd_ok && !pwrite;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_ok_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sub_range_a: assert property (byte_stb && rx_kind == KIND_SUB |-> rx_byte <= SUB_LAST_DIRECT)
    else $error("subaddress above 0E acknowledged");
  incr_step_a: assert property (direct_wr && subaddr_r != SUB_WRAP |=> subaddr_r == $past(subaddr_r) + 8'h01)
    else $error("subaddress did not increment");
  wrap_zero_a: assert property (direct_wr && subaddr_r == SUB_WRAP |=> subaddr_r == SUB_FIRST)
    else $error("subaddress did not wrap to 00");
  single_byte_a: assert property (byte_stb && rx_kind == KIND_DATA && buf_mode_r |-> !data_seen_r)
    else $error("second data byte accepted in buffered mode");
  copy_done_a: assert property (pending_r && vblank_r && !byte_stb |=> !pending_r)
    else $error("buffered byte not copied in blanking");
  busy_nack_a: assert property (pending_r |-> !(byte_stb && rx_kind == KIND_SUB))
    else $error("new transfer acknowledged while copy pending");
  blank_off_a: assert property (sc_pulses.blank |=> !peak_dark_enable)
    else $error("peak dark active in blanking");
  window_lim_a: assert property (peak_dark_enable |-> $past(line_cnt_r) >= $past(win_start)
                                 && $past(line_cnt_r) < $past(win_end))
    else $error("peak dark enabled outside line window");
  shift_gate_a: assert property (!ctrl3_r[C3_ADAPT_BLACK] |=> black_shift == 6'h00)
    else $error("black shift applied while disabled");
  two_level_a: assert property (ctrl1_r[C1_TWO_LEVEL_SC] ##1 ctrl1_r[C1_TWO_LEVEL_SC]
                                |-> sc_pulses.burst == sc_pulses.line)
    else $error("two-level sandcastle split burst and line");
  force_two_a: assert property (ctrl2_r[C2_FORCE2] |=> source_select == SRC_RGB2)
    else $error("forced source two not selected");

  sub_taken_c: cover property (byte_stb && rx_kind == KIND_SUB);
  wrap_seen_c: cover property (direct_wr && subaddr_r == SUB_WRAP);
  buf_copy_c:  cover property (copy_now);
  window_c:    cover property (!peak_dark_enable ##1 peak_dark_enable);

endmodule
`default_nettype wire

// [testbench/twi_ctrl_model.sv]
// Two-wire bus controller model driving the receiver's serial pins
`default_nettype none
module twi_ctrl_model (
  input  wire logic mclk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_low = 1'b0;
  // Open drain with pull-up: a released line reads high
  assign sda = !(pull_low || (sda_oe && !sda_out));
  // Clock stands high between frames
  initial scl = 1'b1;
  task automatic hold();
    repeat (6) @(posedge mclk);
  endtask
  task automatic start();
    pull_low <= 1'b1;
    hold();
    scl <= 1'b0;
    @(posedge mclk);
  endtask
  // MSB first, sampled mid high phase
  task automatic send_bit(input logic b, output logic r);
    pull_low <= !b;
    repeat (5) @(posedge mclk);
    scl <= 1'b1;
    repeat (3) @(posedge mclk);
    r = sda;
    repeat (3) @(posedge mclk);
    scl <= 1'b0;
    // Data moves a cycle after the fall, never with it
    @(posedge mclk);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(b[i], r);
    send_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic stop();
    pull_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    pull_low <= 1'b0;
    hold();
  endtask
endmodule
`default_nettype wire

// [testbench/video_proc_i2c_ctrl_receiver_tb.sv]
// Self-checking bench for the video processor control receiver
`default_nettype none
module video_proc_i2c_ctrl_receiver_tb;
  import vproc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, sda_out, sda_oe, psel, penable, pwrite, pready, pslverr;
  logic source_one_switch_pin, source_two_switch_pin, peak_dark_enable, luma_output_active;
  logic [2:0] sc_compare;
  logic [5:0] peak_dark_result, black_shift, hue_dac, luma_black_level, a;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic e;
  sc_pulses_s sc_pulses;
  source_e source_select;
  ctrl_s ctrl_bits;
  logic [11:0][5:0] align_codes;
  wire scl, sda;
  int n_mismatch = 0;
  int n_checks = 0;
  video_proc_i2c_ctrl_receiver DUT (.mclk, .resetn, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .sc_compare, .source_one_switch_pin, .source_two_switch_pin, .peak_dark_result, .sc_pulses,
    .peak_dark_enable, .black_shift, .luma_output_active, .hue_dac, .luma_black_level, .source_select,
    .ctrl_bits, .align_codes, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  twi_ctrl_model m (.mclk, .sda_oe, .sda_out, .scl, .sda);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic [7:0] ad, input logic w);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= 32'h0000_005A;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic xe);
    apb(ad, 1'b0);
    chk(d, x);
    chk(e, xe);
  endtask
  task automatic xfer(input logic [7:0] b [6], input int n, input logic [5:0] x);
    a = '0;
    m.start();
    for (int i = 0; i < n; i++) m.send_byte(b[i], a[i]);
    m.stop();
    chk(a, x);
  endtask
  task automatic pulses(input logic [2:0] lo, input int n);
    repeat (n) begin
      sc_compare <= lo | 3'b010;
      repeat (4) @(posedge mclk);
      sc_compare <= lo;
      repeat (4) @(posedge mclk);
    end
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sc_compare, source_one_switch_pin, source_two_switch_pin} = '0;
    peak_dark_result = 6'h2A;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(8'h00, 32'h1, 1'b0);
    rd(8'h2C, 32'h1, 1'b0);
    chk(hue_dac, 6'h01);
    chk(black_shift, 6'h00);
    apb(8'h30, 1'b1);
    chk(e, 1'b1);
    rd(8'h30, 32'h0, 1'b0);
    rd(8'h44, 32'h0, 1'b1);
    // Wrap from 0D through 0F back to 00
    xfer('{8'h88, 8'h0D, 8'h01, 8'hA0, 8'h77, 8'hC5}, 6, 6'h3F);
    chk(align_codes[0], 6'h05);
    chk(source_select, SRC_RGB1);
    chk(luma_output_active, 1'b1);
    chk(luma_black_level, 6'h01);
    chk(black_shift, 6'h2A);
    source_two_switch_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(source_select, SRC_RGB2);
    xfer('{8'h88, 8'h0C, 8'h80, 0, 0, 0}, 3, 6'h07);
    sc_compare <= 3'b011;
    repeat (8) @(posedge mclk);
    chk(sc_pulses, 3'b111);
    for (int i = 0; i < 3; i++) xfer('{8'h88, i == 0 ? 8'h0F : i == 1 ? 8'h10 : 8'h8C, 8'hFF, 0, 0, 0}, 3, 6'h01);
    rd(8'h30, 32'h80, 1'b0);
    chk(align_codes[0], 6'h05);
    xfer('{8'h8A, 0, 0, 0, 0, 0}, 1, 6'h00);
    xfer('{8'h89, 0, 0, 0, 0, 0}, 1, 6'h00);
    xfer('{8'h88, 8'h0C, 8'h28, 0, 0, 0}, 3, 6'h07);
    repeat (8) @(posedge mclk);
    chk(sc_pulses, 3'b110);
    chk(ctrl_bits.buffered_write_enable, 1'b1);
    xfer('{8'h88, 8'h00, 8'h11, 8'h22, 0, 0}, 4, 6'h07);
    chk(align_codes[0], 6'h05);
    xfer('{8'h88, 0, 0, 0, 0, 0}, 1, 6'h00);
    pulses(3'b001, 2);
    sc_compare <= 3'b000;
    repeat (4) @(posedge mclk);
    chk(align_codes[0], 6'h11);
    pulses(3'b000, 15);
    chk(peak_dark_enable, 1'b0);
    pulses(3'b000, 2);
    chk(peak_dark_enable, 1'b1);
    pulses(3'b000, 207);
    chk(peak_dark_enable, 1'b0);
    xfer('{8'h88, 0, 0, 0, 0, 0}, 1, 6'h01);
    xfer('{8'h88, 8'h0D, 8'h4C, 0, 0, 0}, 3, 6'h07);
    pulses(3'b001, 2);
    sc_compare <= 3'b000;
    repeat (4) @(posedge mclk);
    chk(source_select, SRC_RGB2);
    pulses(3'b000, 17);
    chk(peak_dark_enable, 1'b0);
    pulses(3'b000, 16);
    chk(peak_dark_enable, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
